// File: pin_sync.sv
`timescale 1ns/100ps
module pin_sync
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic                         ce,
  // Levels
  input  wire logic [pio_pkg::PORT_W-1:0]   async_in,
  output logic      [pio_pkg::PORT_W-1:0]   sync_out
);

  logic [pio_pkg::PORT_W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      stage1   <= pio_pkg::SYNC_RESET;
      sync_out <= pio_pkg::SYNC_RESET;
    end
    else if (ce)
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// File: pio_pin_model.sv
`timescale 1ns/100ps
module pio_pin_model
(
  // Port pad drive
  input  wire pio_pkg::pad_drive_s         pad,
  // External circuit
  input  wire logic [pio_pkg::PORT_W-1:0]  ext_en,
  input  wire logic [pio_pkg::PORT_W-1:0]  ext_val,
  // Resolved pin level
  output logic      [pio_pkg::PORT_W-1:0]  pad_lvl
);
  // Pull-up on every pin, so a released line reads high instead of its last value
  always_comb
  begin
    for (int i = 0; i < pio_pkg::PORT_W; i++)
      pad_lvl[i] = !pad.oe_b[i] ? pad.out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
  end
endmodule

// File: pio_pkg.sv
package pio_pkg;

  localparam int PORT_W = 16;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DRIVEN    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DRAIN     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ANALOG    = 8'h10;

  // Implemented pins and pins with an analog function
  localparam logic [PORT_W-1:0] IMPL_MASK   = 16'h3FFF;
  localparam logic [PORT_W-1:0] ANALOG_MASK = 16'h000F;

  // Reset values
  localparam logic [PORT_W-1:0] DIR_RESET    = IMPL_MASK;
  localparam logic [PORT_W-1:0] LAT_RESET    = 16'h0000;
  localparam logic [PORT_W-1:0] ODC_RESET    = 16'h0000;
  localparam logic [PORT_W-1:0] ANS_RESET    = ANALOG_MASK & IMPL_MASK;
  localparam logic [PORT_W-1:0] SYNC_RESET   = 16'h0000;
  localparam logic [31:0]       RDATA_RESET  = 32'h0000_0000;

  // Bus field layout
  localparam int               BYTE_W      = 8;
  localparam int               STRB_USED   = 2;
  localparam logic [1:0]       RESP_OKAY   = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;
  localparam logic [15:0]      UPPER_ZERO  = 16'h0000;

  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] lat;
    logic [PORT_W-1:0] odc;
    logic [PORT_W-1:0] ans;
  } port_cfg_s;

  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe_b;
  } pad_drive_s;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_e;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_state_e;

endpackage

// File: shared_parallel_io_port.sv
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
// Summary of operation
// - A peripheral that is enabled and actively driving a pin owns it and the port driver is off, the pin still reads.
// - An enabled peripheral that is not driving leaves the pin to the port latch and direction.
// - The peripheral input reads low while the port drives the same pin; port values still in the synchronizer when the port lets go pass through.
// - A direction bit of 1 makes the pin an input with its driver off, 0 makes it an output.
// - Every reset makes all pins inputs.
// - Reading the driven-value store returns the latch and writing it updates the latch.
// - Reading the pin-level register returns sampled pins and writing it updates the latch.
// - A set drain-select bit makes a port-driven output pin (direction 0) open-drain.
// - Analog-select alone chooses analog or digital mode for the pin-level read; direction plays no part.
// - Pins in analog input mode read low in the pin-level register.
// - A set analog-select bit disables the pin-level register read, a clear one enables it; periph_in still sees the pin.
module shared_parallel_io_port
(
  // Clock, reset, enable
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic                         ce,
  // AXI4-Lite write address
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [pio_pkg::ADDR_W-1:0]   awaddr,
  // AXI4-Lite write data
  input  wire logic                         wvalid,
  output logic                              wready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  // AXI4-Lite write response
  output logic                              bvalid,
  input  wire logic                         bready,
  output logic      [1:0]                   bresp,
  // AXI4-Lite read address
  input  wire logic                         arvalid,
  output logic                              arready,
  input  wire logic [pio_pkg::ADDR_W-1:0]   araddr,
  // AXI4-Lite read data
  output logic                              rvalid,
  input  wire logic                         rready,
  output logic      [31:0]                  rdata,
  output logic      [1:0]                   rresp,
  // Sharing peripheral
  input  wire logic [pio_pkg::PORT_W-1:0]   periph_en,
  input  wire logic [pio_pkg::PORT_W-1:0]   periph_drive,
  input  wire logic [pio_pkg::PORT_W-1:0]   periph_out,
  output logic      [pio_pkg::PORT_W-1:0]   periph_in,
  // Pads
  input  wire logic [pio_pkg::PORT_W-1:0]   pad_in,
  output pio_pkg::pad_drive_s               pad
);

  pio_pkg::port_cfg_s           cfg;
  pio_pkg::rd_state_e           rd_state;
  pio_pkg::wr_state_e           wr_state;
  pio_pkg::pad_drive_s          next_pad;
  logic [pio_pkg::PORT_W-1:0]   pin_sync_q;
  logic [pio_pkg::PORT_W-1:0]   pin_level;
  logic [pio_pkg::PORT_W-1:0]   own_vec;
  logic [pio_pkg::PORT_W-1:0]   port_drv;
  logic [pio_pkg::PORT_W-1:0]   next_periph_in;
  logic [pio_pkg::ADDR_W-1:0]   aw_addr_q;
  logic [31:0]                  w_data_q;
  logic [3:0]                   w_strb_q;
  logic                         have_aw;
  logic                         have_w;
  logic                         wr_go;
  logic [pio_pkg::ADDR_W-1:0]   wr_addr;
  logic [31:0]                  wr_data;
  logic [3:0]                   wr_strb;
  logic                         wr_hit;
  logic [31:0]                  next_rdata;
  logic [1:0]                   next_rresp;

  pin_sync u_pin_sync
  (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .async_in (pad_in),
    .sync_out (pin_sync_q)
  );

  // Byte-lane merge; only the two low lanes carry port bits
  function automatic logic [pio_pkg::PORT_W-1:0] merge
  (
    input logic [pio_pkg::PORT_W-1:0] old_v,
    input logic [31:0]                data,
    input logic [3:0]                 strb
  );
    logic [pio_pkg::PORT_W-1:0] res;
    res = old_v;
    for (int i = 0; i < pio_pkg::STRB_USED; i++)
    begin
      if (strb[i])
      begin
        res[i*pio_pkg::BYTE_W +: pio_pkg::BYTE_W] = data[i*pio_pkg::BYTE_W +: pio_pkg::BYTE_W];
      end
    end
    return res & pio_pkg::IMPL_MASK;
  endfunction

  // Write channel bookkeeping: address and data taken in either order
  always_comb
  begin
    have_aw = !awready || awvalid;
    have_w  = !wready || wvalid;
    wr_addr = awready ? awaddr : aw_addr_q;
    wr_data = wready ? wdata : w_data_q;
    wr_strb = wready ? wstrb : w_strb_q;
    wr_go   = (wr_state == pio_pkg::WR_COLLECT) && have_aw && have_w;
    wr_hit  = 1'b1;
    if (wr_addr == pio_pkg::OFS_DIRECTION)
    begin
      wr_hit = 1'b1;
    end
    else if (wr_addr == pio_pkg::OFS_PIN_LEVEL)
    begin
      wr_hit = 1'b1;
    end
    else if (wr_addr == pio_pkg::OFS_DRIVEN)
    begin
      wr_hit = 1'b1;
    end
    else if (wr_addr == pio_pkg::OFS_DRAIN)
    begin
      wr_hit = 1'b1;
    end
    else if (wr_addr == pio_pkg::OFS_ANALOG)
    begin
      wr_hit = 1'b1;
    end
    else
    begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_addr_q <= '0;
      w_data_q  <= pio_pkg::RDATA_RESET;
      w_strb_q  <= '0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      else if (bvalid && bready)
      begin
        awready <= 1'b1;
      end
      if (wvalid && wready)
      begin
        wready   <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      else if (bvalid && bready)
      begin
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_state <= pio_pkg::WR_COLLECT;
      bvalid   <= 1'b0;
      bresp    <= pio_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      case (wr_state)
        pio_pkg::WR_COLLECT:
        begin
          if (wr_go)
          begin
            wr_state <= pio_pkg::WR_RESP;
            bvalid   <= 1'b1;
            bresp    <= wr_hit ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
          end
        end
        pio_pkg::WR_RESP:
        begin
          if (bready)
          begin
            wr_state <= pio_pkg::WR_COLLECT;
            bvalid   <= 1'b0;
          end
        end
        default:
        begin
          wr_state <= pio_pkg::WR_COLLECT;
          bvalid   <= 1'b0;
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cfg.dir <= pio_pkg::DIR_RESET;
      cfg.lat <= pio_pkg::LAT_RESET;
      cfg.odc <= pio_pkg::ODC_RESET;
      cfg.ans <= pio_pkg::ANS_RESET;
    end
    else if (ce && wr_go)
    begin
      if (wr_addr == pio_pkg::OFS_DIRECTION)
      begin
        cfg.dir <= merge(cfg.dir, wr_data, wr_strb);
      end
      else if (wr_addr == pio_pkg::OFS_PIN_LEVEL)
      begin
        // Pin writes land in the latch, never on the pads directly
        cfg.lat <= merge(cfg.lat, wr_data, wr_strb);
      end
      else if (wr_addr == pio_pkg::OFS_DRIVEN)
      begin
        cfg.lat <= merge(cfg.lat, wr_data, wr_strb);
      end
      else if (wr_addr == pio_pkg::OFS_DRAIN)
      begin
        cfg.odc <= merge(cfg.odc, wr_data, wr_strb);
      end
      else if (wr_addr == pio_pkg::OFS_ANALOG)
      begin
        cfg.ans <= merge(cfg.ans, wr_data, wr_strb) & pio_pkg::ANALOG_MASK;
      end
    end
  end

  // Sampled levels, analog pins included; the pin-level read masks analog pins low
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pin_level <= pio_pkg::SYNC_RESET;
    end
    else if (ce)
    begin
      pin_level <= pin_sync_q & pio_pkg::IMPL_MASK;
    end
  end

  // Read channel
  always_comb
  begin
    next_rdata = pio_pkg::RDATA_RESET;
    next_rresp = pio_pkg::RESP_OKAY;
    if (araddr == pio_pkg::OFS_DIRECTION)
    begin
      next_rdata = {pio_pkg::UPPER_ZERO, cfg.dir};
    end
    else if (araddr == pio_pkg::OFS_PIN_LEVEL)
    begin
      next_rdata = {pio_pkg::UPPER_ZERO, pin_level & ~cfg.ans};
    end
    else if (araddr == pio_pkg::OFS_DRIVEN)
    begin
      next_rdata = {pio_pkg::UPPER_ZERO, cfg.lat};
    end
    else if (araddr == pio_pkg::OFS_DRAIN)
    begin
      next_rdata = {pio_pkg::UPPER_ZERO, cfg.odc};
    end
    else if (araddr == pio_pkg::OFS_ANALOG)
    begin
      next_rdata = {pio_pkg::UPPER_ZERO, cfg.ans};
    end
    else
    begin
      next_rresp = pio_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rd_state <= pio_pkg::RD_IDLE;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= pio_pkg::RDATA_RESET;
      rresp    <= pio_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      case (rd_state)
        pio_pkg::RD_IDLE:
        begin
          if (arvalid)
          begin
            rd_state <= pio_pkg::RD_DATA;
            arready  <= 1'b0;
            rvalid   <= 1'b1;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
          end
        end
        pio_pkg::RD_DATA:
        begin
          if (rready)
          begin
            rd_state <= pio_pkg::RD_IDLE;
            arready  <= 1'b1;
            rvalid   <= 1'b0;
          end
        end
        default:
        begin
          rd_state <= pio_pkg::RD_IDLE;
          arready  <= 1'b1;
          rvalid   <= 1'b0;
        end
      endcase
    end
  end

  // Per-pin output multiplexer
  for (genvar i = 0; i < pio_pkg::PORT_W; i++)
  begin : g_pin
    always_comb
    begin
      own_vec[i]        = periph_en[i] && periph_drive[i] && pio_pkg::IMPL_MASK[i];
      port_drv[i]       = !own_vec[i] && !cfg.dir[i] && pio_pkg::IMPL_MASK[i];
      next_pad.out[i]   = 1'b0;
      next_pad.oe_b[i]  = 1'b1;
      if (own_vec[i])
      begin
        next_pad.out[i]  = periph_out[i];
        next_pad.oe_b[i] = 1'b0;
      end
      else if (port_drv[i] && cfg.odc[i])
      begin
        next_pad.oe_b[i] = cfg.lat[i];
      end
      else if (port_drv[i])
      begin
        next_pad.out[i]  = cfg.lat[i];
        next_pad.oe_b[i] = 1'b0;
      end
      // Blocks port data looping into the peripheral
      next_periph_in[i] = pin_sync_q[i] && !port_drv[i] && pio_pkg::IMPL_MASK[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pad.out   <= '0;
      pad.oe_b  <= '1;
      periph_in <= '0;
    end
    else if (ce)
    begin
      pad       <= next_pad;
      periph_in <= next_periph_in;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_dir_after_reset: assert property ($rose(rst_b) |-> cfg.dir == pio_pkg::DIR_RESET)
    else $error("direction not all inputs after reset");
  a_unimpl_zero: assert property (((cfg.dir | cfg.lat | pin_level) & ~pio_pkg::IMPL_MASK) == '0)
    else $error("unimplemented bit not zero");
  a_periph_owns_pin: assert property (ce |=> ((pad.out ^ $past(periph_out)) & $past(own_vec)) == '0)
    else $error("peripheral data not on owned pin");
  a_input_driver_off: assert property (ce |=> (~pad.oe_b & $past(cfg.dir & ~own_vec)) == '0)
    else $error("input pin driven");
  a_push_pull_lat: assert property (ce |=> ((pad.out ^ $past(cfg.lat)) & $past(port_drv & ~cfg.odc)) == '0)
    else $error("port output differs from latch");
  a_od_release: assert property (ce |=> (~pad.oe_b & $past(port_drv & cfg.odc & cfg.lat)) == '0)
    else $error("open drain high not released");
  a_od_low: assert property (ce |=> ((pad.out | pad.oe_b) & $past(port_drv & cfg.odc & ~cfg.lat)) == '0)
    else $error("open drain low not driven low");
  a_loop_block: assert property (ce |=> (periph_in & $past(port_drv)) == '0)
    else $error("port output looped to peripheral");
  a_analog_reads_low: assert property (ce && rd_state == pio_pkg::RD_IDLE && arvalid
                                       && araddr == pio_pkg::OFS_PIN_LEVEL
                                       |=> (rdata[pio_pkg::PORT_W-1:0] & $past(cfg.ans)) == '0)
    else $error("analog pin read high");
  a_level_write_lat: assert property (ce && wr_go && wr_addr == pio_pkg::OFS_PIN_LEVEL && wr_strb == 4'hF
                                      |=> cfg.lat == ($past(wr_data[pio_pkg::PORT_W-1:0]) & pio_pkg::IMPL_MASK))
    else $error("pin-level write missed latch");

endmodule

// File: shared_parallel_io_port_tb_top.sv
`timescale 1ns/100ps
module shared_parallel_io_port_tb_top;
  logic                       clk, rst_b, ce;
  logic                       awvalid, awready, wvalid, wready, bvalid, bready;
  logic                       arvalid, arready, rvalid, rready;
  logic [pio_pkg::ADDR_W-1:0] awaddr, araddr;
  logic [31:0]                wdata, rdata;
  logic [3:0]                 wstrb;
  logic [1:0]                 bresp, rresp;
  logic [15:0]                periph_en, periph_drive, periph_out, periph_in;
  logic [15:0]                pad_lvl, ext_en, ext_val;
  pio_pkg::pad_drive_s        pad;
  int                         fails, checks_done;

  shared_parallel_io_port i_shared_parallel_io_port (.clk(clk), .rst_b(rst_b), .ce(ce), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .periph_en(periph_en),
    .periph_drive(periph_drive), .periph_out(periph_out), .periph_in(periph_in), .pad_in(pad_lvl), .pad(pad));
  pio_pin_model i_pio_pin_model (.pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pad_lvl(pad_lvl));

  always #20 clk = ~clk;

  task automatic conclude;
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tmo;
    fails++;
    conclude();
  endtask

  function automatic logic [31:0] ext32(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (n > 50)
        tmo();
    end
    while (!(bvalid && bready));
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (n > 50)
        tmo();
    end
    while (!(rvalid && rready));
    rready <= 1'b0;
    chk("rdata", exp, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // Pad changes reach periph_in three edges late; two more so the value has landed
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask

  task automatic t_reset;
    rd(pio_pkg::OFS_DIRECTION, ext32(pio_pkg::IMPL_MASK), pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_DRIVEN, 32'h0000_0000, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_DRAIN, 32'h0000_0000, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_ANALOG, ext32(pio_pkg::ANALOG_MASK), pio_pkg::RESP_OKAY);
    chk("pad_oe_b", 32'h0000_FFFF, ext32(pad.oe_b));
  endtask

  task automatic t_regs;
    wr(pio_pkg::OFS_DIRECTION, 32'hFFFF_0000, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_DIRECTION, 32'h0000_0000, pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_DIRECTION, 32'h0000_FFFF, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_DIRECTION, ext32(pio_pkg::IMPL_MASK), pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_DIRECTION, 32'h0000_0000, pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_DRIVEN, 32'h0000_FFFF, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_DRIVEN, ext32(pio_pkg::IMPL_MASK), pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_PIN_LEVEL, 32'h0000_1234, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_DRIVEN, 32'h0000_1234, pio_pkg::RESP_OKAY);
    settle();
    chk("pad_out", 32'h0000_1234, ext32(pad.out & pio_pkg::IMPL_MASK));
    chk("pad_oe_b", 32'h0000_0000, ext32(pad.oe_b & pio_pkg::IMPL_MASK));
    wr(pio_pkg::OFS_DIRECTION, 32'h0000_00FF, pio_pkg::RESP_OKAY);
    settle();
    chk("pad_oe_b", 32'h0000_00FF, ext32(pad.oe_b & pio_pkg::IMPL_MASK));
  endtask

  task automatic t_pins;
    ext_en  <= 16'hFFFF;
    ext_val <= 16'hEA5A;
    wr(pio_pkg::OFS_DIRECTION, 32'h0000_FFFF, pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_ANALOG, 32'h0000_0000, pio_pkg::RESP_OKAY);
    settle();
    rd(pio_pkg::OFS_PIN_LEVEL, 32'h0000_2A5A, pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_ANALOG, 32'h0000_00FF, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_ANALOG, 32'h0000_000F, pio_pkg::RESP_OKAY);
    settle();
    rd(pio_pkg::OFS_PIN_LEVEL, 32'h0000_2A50, pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_ANALOG, 32'h0000_0000, pio_pkg::RESP_OKAY);
    ext_en <= 16'h0000;
  endtask

  task automatic t_drain;
    wr(pio_pkg::OFS_DIRECTION, 32'h0000_0000, pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_DRAIN, 32'h0000_00FF, pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_DRIVEN, 32'h0000_00F0, pio_pkg::RESP_OKAY);
    settle();
    chk("pad_out", 32'h0000_0000, ext32(pad.out & 16'h00FF));
    chk("pad_oe_b", 32'h0000_00F0, ext32(pad.oe_b & pio_pkg::IMPL_MASK));
    rd(pio_pkg::OFS_PIN_LEVEL, 32'h0000_00F0, pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_DRAIN, 32'h0000_0000, pio_pkg::RESP_OKAY);
  endtask

  task automatic t_periph;
    wr(pio_pkg::OFS_DRIVEN, 32'h0000_0002, pio_pkg::RESP_OKAY);
    periph_en    <= 16'h0003;
    periph_drive <= 16'h0001;
    periph_out   <= 16'h0001;
    settle();
    chk("pad_out", 32'h0000_0003, ext32(pad.out & 16'h0003));
    chk("pad_oe_b", 32'h0000_0000, ext32(pad.oe_b & 16'h0003));
    chk("periph_in", 32'h0000_0001, ext32(periph_in & 16'h0003));
    rd(pio_pkg::OFS_PIN_LEVEL, 32'h0000_0003, pio_pkg::RESP_OKAY);
    periph_en <= 16'h0000;
  endtask

  task automatic t_rereset;
    wr(pio_pkg::OFS_DIRECTION, 32'h0000_0000, pio_pkg::RESP_OKAY);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    rd(pio_pkg::OFS_DIRECTION, ext32(pio_pkg::IMPL_MASK), pio_pkg::RESP_OKAY);
    chk("pad_oe_b", 32'h0000_FFFF, ext32(pad.oe_b));
    wr(pio_pkg::OFS_DIRECTION, 32'h0000_0000, pio_pkg::RESP_OKAY);
  endtask

  task automatic t_unmapped;
    rd(8'h14, 32'h0000_0000, pio_pkg::RESP_SLVERR);
    wr(8'h14, 32'h0000_FFFF, pio_pkg::RESP_SLVERR);
    rd(pio_pkg::OFS_DIRECTION, 32'h0000_0000, pio_pkg::RESP_OKAY);
  endtask

  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    {periph_en, periph_drive, periph_out, ext_en, ext_val} = '0;
    fails = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_pins();
    t_drain();
    t_periph();
    t_rereset();
    t_unmapped();
    conclude();
  end
endmodule
